// ---- verification/e1p_far_end.sv ----
// Far-end E1 equipment model: free-running line clock, frame markers, line data.
// Assumes the bench steers the pattern, fixed-octet, bit-flip and loopback modes.
`timescale 1ns/1ps
module e1p_far_end (
  output logic            lclk,
  output logic            rframe,
  output logic            tframe,
  output logic            ldata,
  input  wire logic       pat_en,
  input  wire logic       loop_en,
  input  wire logic       flip_en,
  input  wire logic [4:0] slot,
  input  wire logic [7:0] octet,
  input  wire logic       tx_bit
);
  logic [7:0]  cnt;
  logic [7:0]  nb;
  logic [14:0] sr;

  // ==========================================================================
  // Line clock runs free, as a real line clock does between frames
  initial begin
    lclk = 1'b0;
    cnt = 8'hff;
    sr = 15'h7fff;
    rframe = 1'b0;
    tframe = 1'b0;
    ldata = 1'b1;
  end
  always #62.5 lclk = ~lclk;
  always @(posedge lclk) cnt <= cnt + 8'h01;

  // ==========================================================================
  // Next bit is launched half a period ahead of the edge that samples it
  always @(negedge lclk) begin
    nb = cnt + 8'h01;
    tframe <= (nb == 8'h00);
    rframe <= (nb == {7'h00, loop_en}); // Loopback costs one bit, so the marker moves too
    if (loop_en) begin
      ldata <= tx_bit ^ flip_en;
    end else if (pat_en) begin
      ldata <= sr[14] ^ flip_en;
      sr <= {sr[13:0], sr[14] ^ sr[13]};
    end else begin
      ldata <= (nb[7:3] == slot) ? octet[3'h7 - nb[2:0]] : 1'b1; // Idle ones elsewhere
    end
  end
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the E1 pattern test and slot monitor block.
// Assumes the far-end model drives both line clocks, markers and receive data.
`timescale 1ns/1ps
module tb
  import e1p_pkg::*;
();
  logic        clk, nrst, avs_read, avs_write, avs_waitrequest;
  logic [6:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic        rclk, rdata, rframe, tframe, tdata_out, li_b, al_b, er_b, ua, ub, irq;
  logic        pat_en, loop_en, flip_en, ua_q, eb;
  logic [7:0]  rd;
  int          err_total, compares, pulses;
  // Rows: address, write data, expected read back
  logic [22:0] rows [5] = '{{7'h14, 8'h0f, 8'h0f}, {7'h15, 8'h0f, 8'h0f},
                            {7'h16, 8'h0e, 8'h0e}, {7'h16, 8'h00, 8'h00},
                            {7'h30, 8'h5a, 8'h00}};

  // ==========================================================================
  // Design and far end; transmit shares the line clock, normal traffic loops in
  e1p_prbs_monitor dut (.clk(clk), .nrst(nrst), .ce(1'b1), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rclk(rclk), .rdata(rdata), .rframe(rframe), .tclk(rclk), .tframe(tframe),
    .tdata_in(rdata), .tdata_out(tdata_out), .ebit_error(eb),
    .line_interface_reset_bit(li_b), .rx_elastic_align_bit(al_b),
    .rx_elastic_reset_bit(er_b), .user_output_a(ua), .user_output_b(ub), .irq(irq));
  e1p_far_end far (.lclk(rclk), .rframe(rframe), .tframe(tframe), .ldata(rdata),
    .pat_en(pat_en), .loop_en(loop_en), .flip_en(flip_en), .slot(5'h0f),
    .octet(8'hb4), .tx_bit(tdata_out));

  // ==========================================================================
  // Clock, error pulse counter and watchdog
  initial clk = 1'b0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    if (ua === 1'b1 && ua_q === 1'b0) pulses++;
    ua_q <= ua;
  end
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    finish_test;
  end

  // ==========================================================================
  // Shared tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Request held until waitrequest is seen low; that edge completes it
  task bus(input logic wr, input logic [6:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) err_total++;
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task rdchk(input logic [6:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    check({24'h000000, rd}, {24'h000000, e});
  endtask
  task lbits(input int n);
    repeat (n) @(posedge rclk);
  endtask
  task flip(input int n);
    @(posedge rclk);
    flip_en <= 1'b1;
    lbits(n);
    flip_en <= 1'b0;
  endtask
  // Framer E-bit error strobe held for n system clocks
  task ebit(input int n);
    @(posedge clk);
    eb <= 1'b1;
    repeat (n) @(posedge clk);
    eb <= 1'b0;
  endtask
  task finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 7'h00;
    avs_writedata = 32'h00000000;
    pat_en = 1'b0;
    loop_en = 1'b0;
    flip_en = 1'b0;
    eb = 1'b0;
    err_total = 0;
    compares = 0;
    pulses = 0;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rdchk(E1P_IDX_RX_MON_CTL, E1P_CTL_RST);
    rdchk(E1P_IDX_PAT_MODE, E1P_CTL_RST);
    // Channel 15 selected in both directions by its plain binary number
    foreach (rows[i]) begin
      bus(1'b1, rows[i][22:16], rows[i][15:8]);
      rdchk(rows[i][22:16], rows[i][7:0]);
    end
    // Normal receive mode: the shared counter counts framer E-bit errors
    ebit(3);
    rdchk(E1P_IDX_ECNT_LO, 8'h03);
    lbits(400);
    rdchk(E1P_IDX_RX_SLOT_MON, 8'hb4);
    rdchk(E1P_IDX_TX_SLOT_MON, 8'hb4);
    bus(1'b1, E1P_IDX_RX_MON_CTL, 8'hef);
    @(posedge clk);
    check({29'h0, li_b, al_b, er_b}, 32'h7);
    // Unframed pattern from the far end: sync, one error, then a burst
    pat_en <= 1'b1;
    bus(1'b1, E1P_IDX_USER_OUT, 8'h09); // A pulses on errors, B stands high
    bus(1'b1, E1P_IDX_IRQ_ENABLE, 8'h07);
    bus(1'b1, E1P_IDX_PAT_MODE, 8'h03);
    lbits(100);
    rdchk(E1P_IDX_STATUS2, 8'h01);
    check({31'h0, irq}, 32'h1);
    check({31'h0, ub}, 32'h1);
    bus(1'b1, E1P_IDX_IRQ_CLEAR, 8'h07);
    bus(1'b1, E1P_IDX_ECNT_LO, 8'h00);
    check({31'h0, irq}, 32'h0);
    pulses = 0;
    ebit(2); // Ignored while the counter counts pattern errors
    flip(1);
    lbits(20);
    rdchk(E1P_IDX_ECNT_LO, 8'h01);
    rdchk(E1P_IDX_ECNT_HI, 8'h00);
    check(pulses, 32'h1);
    rdchk(E1P_IDX_STATUS2, 8'h01);
    check({31'h0, irq}, 32'h1);
    // Twelve straight errors put at least six inside one 64-bit span
    flip(12);
    lbits(100);
    bus(1'b0, E1P_IDX_IRQ_STATUS, 8'h00);
    check({24'h0, rd & 8'h02}, 32'h2);
    bus(1'b1, E1P_IDX_IRQ_ENABLE, 8'h00);
    @(posedge clk);
    check({31'h0, irq}, 32'h0);
    // Device pattern looped back: unframed, then framed
    loop_en <= 1'b1;
    for (int m = 3; m >= 2; m--) begin
      bus(1'b1, E1P_IDX_PAT_MODE, {4'h0, m[1:0], m[1:0]});
      lbits(190);
      rdchk(E1P_IDX_STATUS2, 8'h01);
    end
    bus(1'b1, E1P_IDX_PAT_MODE, 8'h00);
    lbits(4);
    rdchk(E1P_IDX_STATUS2, 8'h00);
    // Second reset in mid-run
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rdchk(E1P_IDX_RX_MON_CTL, 8'h00);
    check({29'h0, li_b, al_b, er_b}, 32'h0);
    // Single-slot mode in loopback from a fresh generator; start at a frame edge
    // so the first pattern octet in slot 15 is the top of the seed
    bus(1'b1, E1P_IDX_TX_MON_CTL, 8'h0f);
    bus(1'b1, E1P_IDX_RX_MON_CTL, 8'h0f);
    @(posedge tframe);
    bus(1'b1, E1P_IDX_PAT_MODE, 8'h05);
    lbits(200);
    rdchk(E1P_IDX_TX_SLOT_MON, E1P_LFSR_SEED[14:7]);
    // Eight pattern bits a frame: six frames fill the checker and its good run
    lbits(1300);
    rdchk(E1P_IDX_STATUS2, 8'h01);
    finish_test;
  end
endmodule

// ---- verilog/e1p_pkg.sv ----
// Constants, types and register map of the E1 pattern test and slot monitor block.
// Assumes a single 250 MHz system clock; line clocks arrive as slow pins.
package e1p_pkg;

  // ==========================================================================
  // Register indices (Avalon word addresses)
  localparam logic [6:0] E1P_IDX_TX_MON_CTL  = 7'h14;
  localparam logic [6:0] E1P_IDX_RX_MON_CTL  = 7'h15;
  localparam logic [6:0] E1P_IDX_PAT_MODE    = 7'h16;
  localparam logic [6:0] E1P_IDX_TX_SLOT_MON = 7'h22;
  localparam logic [6:0] E1P_IDX_RX_SLOT_MON = 7'h2a;
  localparam logic [6:0] E1P_IDX_IRQ_STATUS  = 7'h40;
  localparam logic [6:0] E1P_IDX_IRQ_CLEAR   = 7'h41;
  localparam logic [6:0] E1P_IDX_IRQ_ENABLE  = 7'h42;
  localparam logic [6:0] E1P_IDX_ECNT_HI     = 7'h43;
  localparam logic [6:0] E1P_IDX_ECNT_LO     = 7'h44;
  localparam logic [6:0] E1P_IDX_STATUS2     = 7'h45;
  localparam logic [6:0] E1P_IDX_USER_OUT    = 7'h46;

  // ==========================================================================
  // Field positions and reset values
  localparam int         E1P_LINE_INTERFACE_RESET_BIT_BIT  = 7;
  localparam int         E1P_ALIGN_BIT  = 6;
  localparam int         E1P_ERESET_BIT = 5;
  localparam int         E1P_SYNC_BIT   = 0;
  localparam int         E1P_IRQ_GAIN   = 0;
  localparam int         E1P_IRQ_LOSS   = 1;
  localparam int         E1P_IRQ_ERR    = 2;
  localparam int         E1P_UO_A_ERR   = 0;
  localparam int         E1P_UO_B_ERR   = 1;
  localparam int         E1P_UO_A_LVL   = 2;
  localparam int         E1P_UO_B_LVL   = 3;
  localparam logic [7:0] E1P_CTL_RST    = 8'h00;

  // ==========================================================================
  // Pattern and checker counts
  localparam int          E1P_LFSR_LEN  = 15;
  localparam logic [14:0] E1P_LFSR_SEED = 15'h7fff;
  localparam logic [5:0]  E1P_GOOD_RUN  = 6'h20;   // Error-free bits needed for sync
  localparam logic [5:0]  E1P_WIN_LAST  = 6'h3f;   // 64-bit span, last index
  localparam logic [2:0]  E1P_ERR_LIMIT = 3'h6;
  localparam logic [15:0] E1P_CNT_MAX   = 16'hffff;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    E1P_NORMAL   = 2'b00,
    E1P_ONE_SLOT = 2'b01,
    E1P_FRAMED   = 2'b10,
    E1P_UNFRAMED = 2'b11
  } e1p_mode_t;

  typedef enum logic [0:0] {
    E1P_HUNT = 1'b0,
    E1P_SYNC = 1'b1
  } e1p_chk_t;

  // One sampled line: its clock level, data and frame marker
  typedef struct packed {
    logic lclk;
    logic data;
    logic frame;
  } e1p_line_t;

endpackage

// ---- verilog/e1p_prbs_monitor.sv ----
// Pattern generator, pattern checker and slot monitors for one E1 framer.
// Assumes line clocks, data and frame markers are slow pins sampled by clk.
`timescale 1ns/1ps
module e1p_prbs_monitor
  import e1p_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rclk,
  input  wire logic        rdata,
  input  wire logic        rframe,
  input  wire logic        tclk,
  input  wire logic        tframe,
  input  wire logic        tdata_in,
  output logic             tdata_out,
  input  wire logic        ebit_error,
  output logic             line_interface_reset_bit,
  output logic             rx_elastic_align_bit,
  output logic             rx_elastic_reset_bit,
  output logic             user_output_a,
  output logic             user_output_b,
  output logic             irq
);

  // ==========================================================================
  // Registers and state
  logic [7:0]  tx_ctl_reg, rx_ctl_reg, mode_reg, uo_reg;
  logic [7:0]  tx_mon_reg, rx_mon_reg, tx_sh_reg, rx_sh_reg;
  logic [2:0]  irq_sts_reg, irq_en_reg;
  logic [15:0] ecnt_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  e1p_line_t   rx_s1_reg, rx_s2_reg, tx_s1_reg, tx_s2_reg;
  logic        rclk_prev_reg, tclk_prev_reg;
  logic [7:0]  rx_cnt_reg, tx_cnt_reg;
  logic [14:0] gen_reg, chk_reg;
  e1p_chk_t    chk_state_reg;
  logic [5:0]  good_reg, win_reg;
  logic [2:0]  werr_reg;
  logic        bit_err_reg, err_pulse_reg, gain_reg, loss_reg;

  e1p_mode_t   tx_mode, rx_mode;
  logic        rx_rise, rx_fall, tx_rise;
  logic [7:0]  rx_pos, tx_pos;
  logic        rx_pat, tx_pat, rx_pred, rx_err;
  logic [2:0]  werr_next;
  logic        wr_ok, rd_take;

  assign tx_mode = e1p_mode_t'(mode_reg[3:2]);
  assign rx_mode = e1p_mode_t'(mode_reg[1:0]);

  // Slot membership of a bit position for a pattern mode
  function automatic logic in_pattern(e1p_mode_t m, logic [7:0] pos, logic [4:0] sel);
    logic r;
    r = 1'b0;
    case (m)
      E1P_ONE_SLOT: r = (pos[7:3] == sel);
      E1P_FRAMED:   r = (pos[7:3] != 5'h00);
      E1P_UNFRAMED: r = 1'b1;
      default:      r = 1'b0;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Pin synchronisers; only the second stage is looked at
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_s1_reg     <= '0;
      rx_s2_reg     <= '0;
      tx_s1_reg     <= '0;
      tx_s2_reg     <= '0;
      rclk_prev_reg <= 1'b0;
      tclk_prev_reg <= 1'b0;
    end else if (ce) begin
      rx_s1_reg     <= '{lclk: rclk, data: rdata, frame: rframe};
      rx_s2_reg     <= rx_s1_reg;
      tx_s1_reg     <= '{lclk: tclk, data: tdata_in, frame: tframe};
      tx_s2_reg     <= tx_s1_reg;
      rclk_prev_reg <= rx_s2_reg.lclk;
      tclk_prev_reg <= tx_s2_reg.lclk;
    end
  end

  // Line clock edges found in the system domain
  assign rx_rise = ce & rx_s2_reg.lclk & ~rclk_prev_reg;
  assign rx_fall = ce & ~rx_s2_reg.lclk & rclk_prev_reg;
  assign tx_rise = ce & tx_s2_reg.lclk & ~tclk_prev_reg;

  // Frame marker restarts the count at bit 0 of slot zero
  assign rx_pos = rx_s2_reg.frame ? 8'h00 : rx_cnt_reg + 8'h01;
  assign tx_pos = tx_s2_reg.frame ? 8'h00 : tx_cnt_reg + 8'h01;
  assign rx_pat = in_pattern(rx_mode, rx_pos, rx_ctl_reg[4:0]);
  assign tx_pat = in_pattern(tx_mode, tx_pos, tx_ctl_reg[4:0]);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_cnt_reg <= 8'hff;
      tx_cnt_reg <= 8'hff;
    end else begin
      if (rx_rise) begin
        rx_cnt_reg <= rx_pos;
      end
      if (tx_rise) begin
        tx_cnt_reg <= tx_pos;
      end
    end
  end

  // ==========================================================================
  // Transmit: generator and line data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      gen_reg   <= E1P_LFSR_SEED;
      tdata_out <= 1'b0;
    end else if (tx_rise) begin
      if (tx_pat) begin
        tdata_out <= gen_reg[14];
        gen_reg   <= {gen_reg[13:0], gen_reg[14] ^ gen_reg[13]};
      end else begin
        tdata_out <= tx_s2_reg.data;
      end
    end
  end

  // Transmit slot monitor; first sent bit lands in bit 7
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_sh_reg  <= 8'h00;
      tx_mon_reg <= 8'h00;
    end else if (tx_rise && tx_pos[7:3] == tx_ctl_reg[4:0]) begin
      tx_sh_reg <= {tx_sh_reg[6:0], tx_pat ? gen_reg[14] : tx_s2_reg.data};
      if (tx_pos[2:0] == 3'h7) begin
        tx_mon_reg <= {tx_sh_reg[6:0], tx_pat ? gen_reg[14] : tx_s2_reg.data};
      end
    end
  end

  // ==========================================================================
  // Receive slot monitor; copies the selected octet, MSB first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_sh_reg  <= 8'h00;
      rx_mon_reg <= 8'h00;
    end else if (rx_rise && rx_pos[7:3] == rx_ctl_reg[4:0]) begin
      rx_sh_reg <= {rx_sh_reg[6:0], rx_s2_reg.data};
      if (rx_pos[2:0] == 3'h7) begin
        rx_mon_reg <= {rx_sh_reg[6:0], rx_s2_reg.data};
      end
    end
  end

  // ==========================================================================
  // Receive checker. Hunting self-loads from the line; once in sync the local
  // sequence free-runs so a single line error is counted once, not three times.
  assign rx_pred   = chk_reg[14] ^ chk_reg[13];
  assign rx_err    = rx_s2_reg.data ^ rx_pred;
  assign werr_next = werr_reg + {2'b00, rx_err};

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      chk_state_reg <= E1P_HUNT;
      chk_reg       <= 15'h0000;
      good_reg      <= 6'h00;
      win_reg       <= 6'h00;
      werr_reg      <= 3'h0;
      bit_err_reg   <= 1'b0;
      gain_reg      <= 1'b0;
      loss_reg      <= 1'b0;
    end else if (ce) begin
      bit_err_reg <= 1'b0;
      gain_reg    <= 1'b0;
      loss_reg    <= 1'b0;
      if (rx_mode == E1P_NORMAL) begin
        chk_state_reg <= E1P_HUNT;
        good_reg      <= 6'h00;
      end else if (rx_rise && rx_pat) begin
        case (chk_state_reg)
          E1P_HUNT: begin
            chk_reg  <= {chk_reg[13:0], rx_s2_reg.data};
            good_reg <= rx_err ? 6'h00 : good_reg + 6'h01;
            if (!rx_err && good_reg == E1P_GOOD_RUN - 6'h01) begin
              chk_state_reg <= E1P_SYNC;
              gain_reg      <= 1'b1;
              win_reg       <= 6'h00;
              werr_reg      <= 3'h0;
            end
          end
          E1P_SYNC: begin
            chk_reg     <= {chk_reg[13:0], rx_pred};
            bit_err_reg <= rx_err;
            win_reg     <= win_reg + 6'h01;
            werr_reg    <= (win_reg == E1P_WIN_LAST) ? 3'h0 : werr_next;
            if (werr_next >= E1P_ERR_LIMIT) begin
              chk_state_reg <= E1P_HUNT;
              loss_reg      <= 1'b1;
              good_reg      <= 6'h00;
            end
          end
          default: begin
            chk_state_reg <= E1P_HUNT;
          end
        endcase
      end
    end
  end

  // Error pulse: rises with the error, falls on the next falling line clock
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      err_pulse_reg <= 1'b0;
    end else if (ce && bit_err_reg) begin
      err_pulse_reg <= 1'b1;
    end else if (rx_fall) begin
      err_pulse_reg <= 1'b0;
    end
  end

  assign user_output_a = uo_reg[E1P_UO_A_ERR] ? err_pulse_reg : uo_reg[E1P_UO_A_LVL];
  assign user_output_b = uo_reg[E1P_UO_B_ERR] ? err_pulse_reg : uo_reg[E1P_UO_B_LVL];

  // ==========================================================================
  // Error counter, shared between E-bit errors and pattern errors; saturates
  logic cnt_hit;
  // Gated by ce so a held error flag cannot count while the block is frozen
  assign cnt_hit = ce & ((rx_mode != E1P_NORMAL) ? bit_err_reg : ebit_error);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ecnt_reg <= 16'h0000;
    end else if (wr_ok && (avs_address == E1P_IDX_ECNT_HI || avs_address == E1P_IDX_ECNT_LO)) begin
      ecnt_reg <= {15'h0000, cnt_hit};
    end else if (cnt_hit && ecnt_reg != E1P_CNT_MAX) begin
      ecnt_reg <= ecnt_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // Avalon slave: one wait cycle; a read is sampled during it, a write is taken after it
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign wr_ok   = ce & avs_write & ack_reg & avs_byteenable[0];
  assign rd_take = ce & avs_read & ~ack_reg;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_reg <= 1'b0;
    end else if (ce) begin
      ack_reg <= (avs_read | avs_write) & ~ack_reg;
    end
  end

  // Software-written control registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_ctl_reg <= E1P_CTL_RST;
      rx_ctl_reg <= E1P_CTL_RST;
      mode_reg   <= E1P_CTL_RST;
      uo_reg     <= E1P_CTL_RST;
      irq_en_reg <= 3'h0;
    end else if (wr_ok) begin
      case (avs_address)
        E1P_IDX_TX_MON_CTL: tx_ctl_reg <= avs_writedata[7:0];
        E1P_IDX_RX_MON_CTL: rx_ctl_reg <= avs_writedata[7:0];
        E1P_IDX_PAT_MODE:   mode_reg   <= {4'h0, avs_writedata[3:0]};
        E1P_IDX_USER_OUT:   uo_reg     <= {4'h0, avs_writedata[3:0]};
        E1P_IDX_IRQ_ENABLE: irq_en_reg <= avs_writedata[2:0];
        default:            irq_en_reg <= irq_en_reg;
      endcase
    end
  end

  // Bits owned by neighbouring blocks, passed straight out
  assign line_interface_reset_bit = rx_ctl_reg[E1P_LINE_INTERFACE_RESET_BIT_BIT];
  assign rx_elastic_align_bit     = rx_ctl_reg[E1P_ALIGN_BIT];
  assign rx_elastic_reset_bit     = rx_ctl_reg[E1P_ERESET_BIT];

  // Sticky events; a new event beats a clear in the same cycle
  logic [2:0] irq_ev, irq_clr;
  assign irq_ev  = {bit_err_reg, loss_reg, gain_reg};
  assign irq_clr = (wr_ok && avs_address == E1P_IDX_IRQ_CLEAR) ? avs_writedata[2:0] : 3'h0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      irq_sts_reg <= 3'h0;
    end else if (ce) begin
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_ev;
    end
  end

  assign irq = |(irq_sts_reg & irq_en_reg);

  // Read mux; unmapped and write-only addresses read as zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_take) begin
      case (avs_address)
        E1P_IDX_TX_MON_CTL:  rdata_reg <= {24'h0, tx_ctl_reg};
        E1P_IDX_RX_MON_CTL:  rdata_reg <= {24'h0, rx_ctl_reg};
        E1P_IDX_PAT_MODE:    rdata_reg <= {24'h0, mode_reg};
        E1P_IDX_TX_SLOT_MON: rdata_reg <= {24'h0, tx_mon_reg};
        E1P_IDX_RX_SLOT_MON: rdata_reg <= {24'h0, rx_mon_reg};
        E1P_IDX_IRQ_STATUS:  rdata_reg <= {29'h0, irq_sts_reg};
        E1P_IDX_IRQ_ENABLE:  rdata_reg <= {29'h0, irq_en_reg};
        E1P_IDX_ECNT_HI:     rdata_reg <= {24'h0, ecnt_reg[15:8]};
        E1P_IDX_ECNT_LO:     rdata_reg <= {24'h0, ecnt_reg[7:0]};
        E1P_IDX_STATUS2:     rdata_reg <= {31'h0, chk_state_reg == E1P_SYNC};
        E1P_IDX_USER_OUT:    rdata_reg <= {24'h0, uo_reg};
        default:             rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata = rdata_reg;

  // ==========================================================================
  // Assertions
  sequence rx_take_s;
    rx_rise && rx_pat;
  endsequence

  sequence rx_last_bit_s;
    rx_rise && rx_pos[7:3] == rx_ctl_reg[4:0] && rx_pos[2:0] == 3'h7;
  endsequence

  sequence sync_err_s;
    chk_state_reg == E1P_SYNC && rx_mode != E1P_NORMAL && rx_err;
  endsequence

  AST_RX_MON: assert property (@(posedge clk) disable iff (!nrst)
    rx_last_bit_s |=> rx_mon_reg == {$past(rx_sh_reg[6:0]), $past(rx_s2_reg.data)})
    else $error("receive slot monitor holds wrong octet");

  AST_TX_MON: assert property (@(posedge clk) disable iff (!nrst)
    tx_rise && !tx_pat && tx_pos == {tx_ctl_reg[4:0], 3'h7}
    |=> tx_mon_reg[0] == tdata_out)
    else $error("transmit slot monitor last bit differs from line");

  AST_GEN_STEP: assert property (@(posedge clk) disable iff (!nrst)
    tx_rise && tx_pat
    |=> gen_reg == {$past(gen_reg[13:0]), $past(gen_reg[14]) ^ $past(gen_reg[13])})
    else $error("generator stepped wrongly");

  AST_TX_PAT: assert property (@(posedge clk) disable iff (!nrst)
    tx_rise && tx_pat |=> tdata_out == $past(gen_reg[14]))
    else $error("pattern bit not sent in pattern slot");

  AST_TX_PASS: assert property (@(posedge clk) disable iff (!nrst)
    tx_rise && !tx_pat |=> tdata_out == $past(tx_s2_reg.data))
    else $error("traffic not passed outside pattern slots");

  AST_LOSS: assert property (@(posedge clk) disable iff (!nrst)
    rx_take_s and sync_err_s and (werr_reg == 3'h5)
    |=> chk_state_reg == E1P_HUNT && loss_reg)
    else $error("sync kept after sixth error in span");

  AST_CNT: assert property (@(posedge clk) disable iff (!nrst)
    ce && bit_err_reg && rx_mode != E1P_NORMAL && ecnt_reg != E1P_CNT_MAX && !wr_ok
    |=> ecnt_reg == $past(ecnt_reg) + 16'h0001)
    else $error("pattern error not counted");

  AST_PULSE: assert property (@(posedge clk) disable iff (!nrst)
    bit_err_reg && uo_reg[E1P_UO_A_ERR] && $stable(uo_reg) ##1 $stable(uo_reg)
    |-> user_output_a)
    else $error("error pulse missing on user output");

  AST_IRQ_SET: assert property (@(posedge clk) disable iff (!nrst)
    ce && gain_reg |=> irq_sts_reg[E1P_IRQ_GAIN] && chk_state_reg == E1P_SYNC)
    else $error("sync gain not recorded");

endmodule
